// [rtl/ppop_pkg.sv]
package ppop_pkg;
	// Input bus and register word layout.
	localparam int DIN_W = 64;
	localparam int PROG_W = 32;
	localparam int REG_ADDR_HI = 31;
	localparam int REG_ADDR_LO = 24;
	localparam int REG_DATA_W = 24;
	// Palette geometry.
	localparam int LUT_DEPTH = 256;
	localparam int LUT_AW = 8;
	localparam int LUT_W = 28;
	localparam int LUT_SEGS = 8;
	localparam int CUR_W = 32;
	localparam int CUR_COLS = 4;
	// Control register addresses (upper byte of the programming word).
	localparam logic [7:0] A_LUT_PTR = 8'h10;
	localparam logic [7:0] A_LUT_DATA = 8'h11;
	localparam logic [7:0] A_LUT_EXT = 8'h12;
	localparam logic [7:0] A_CUR_COL1 = 8'h41;
	localparam logic [7:0] A_CUR_COL2 = 8'h42;
	localparam logic [7:0] A_CUR_COL3 = 8'h43;
	localparam logic [7:0] A_CUR_EXT = 8'h44;
	localparam logic [7:0] A_CTRL = 8'hE0;
	localparam logic [7:0] A_CUR_LINE = 8'h48;
	// Control register fields.
	localparam int C_DIV_LO = 0;
	localparam int C_SRC_LO = 3;
	localparam int C_BPP_LO = 5;
	localparam int C_MODE_LO = 8;
	localparam int C_BUS_LO = 10;
	localparam logic [23:0] CTRL_RST = 24'h000000;
	// Port source select encodings.
	localparam logic [1:0] SEL_RED = 2'h0;
	localparam logic [1:0] SEL_GRN = 2'h1;
	localparam logic [1:0] SEL_BLU = 2'h2;
	localparam logic [1:0] SEL_EXT = 2'h3;
	localparam int PANEL_DIV = 4;
	typedef enum logic [2:0] {
		BPP1 = 3'b000, BPP2 = 3'b001, BPP4 = 3'b010, BPP8 = 3'b011, BPP16 = 3'b100, BPP32 = 3'b101
	} ppop_bpp_e;
	typedef enum logic [1:0] {
		MODE_CRT = 2'b00, MODE_HIGH_RESOLUTION_MODE = 2'b01, MODE_ILACE = 2'b10, MODE_PANEL = 2'b11
	} ppop_mode_e;
	typedef enum logic [1:0] {
		BUS_ASYNC32 = 2'b00, BUS_SYNC64 = 2'b01, BUS_VRAM = 2'b10, BUS_SPLIT = 2'b11
	} ppop_bus_e;
endpackage

// [rtl/ppop_top.sv]
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
module ppop_top
	import ppop_pkg::*;
#(
	parameter int DEPTH = LUT_DEPTH
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// Register programming and pixel data input.
	input wire logic register_write_strobe_n,
	input wire logic [DIN_W-1:0] din,
	input wire logic din_valid,
	input wire logic memory_bus_clock,
	// Pixel clock sources.
	input wire logic [2:0] pix_src_en,
	// Cursor presence on the current pixel run.
	input wire logic cursor_active,
	// Port source and outputs.
	input wire logic [1:0] port_source_select,
	output logic [7:0] digital_output_port,
	output logic port_output_clock,
	output logic [7:0] red_out,
	output logic [7:0] green_out,
	output logic [7:0] blue_out,
	output logic [3:0] external_table_bits,
	output logic [LUT_SEGS-1:0] seg_enable
);

	// ============================================================
	// Register writes
	logic [LUT_W-1:0] lut_q [DEPTH];
	logic [LUT_W-1:0] cur_q [CUR_COLS];
	logic [LUT_AW-1:0] ptr_q;
	logic [23:0] ctrl_q;
	logic [CUR_W*2-1:0] cur_line_q;
	logic [PROG_W-1:0] prog;
	logic [7:0] radr;
	logic [23:0] rdat;
	logic wr;

	assign prog = din[PROG_W-1:0];
	assign radr = prog[REG_ADDR_HI:REG_ADDR_LO];
	assign rdat = prog[REG_DATA_W-1:0];
	assign wr = ~register_write_strobe_n;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ptr_q <= 8'h00;
		end else if (wr && radr == A_LUT_PTR) begin
			ptr_q <= rdat[LUT_AW-1:0];
		end else if (wr && (radr == A_LUT_DATA || radr == A_LUT_EXT)) begin
			ptr_q <= ptr_q + 8'h01;
		end
	end

	// Entry write: A_LUT_DATA loads RGB keeping external bits, A_LUT_EXT loads the 4 external bits keeping RGB.
	// The palette clears at reset, so no unknown colour can reach the outputs.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < DEPTH; i++) begin
				lut_q[i] <= 28'h0000000;
			end
		end else if (wr && radr == A_LUT_DATA) begin
			lut_q[ptr_q] <= {lut_q[ptr_q][27:24], rdat};
		end else if (wr && radr == A_LUT_EXT) begin
			lut_q[ptr_q] <= {rdat[3:0], lut_q[ptr_q][23:0]};
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cur_q[0] <= 28'h0000000;
			cur_q[1] <= 28'h0000000;
			cur_q[2] <= 28'h0000000;
			cur_q[3] <= 28'h0000000;
		end else if (wr) begin
			case (radr)
				A_CUR_COL1: cur_q[1][23:0] <= rdat;
				A_CUR_COL2: cur_q[2][23:0] <= rdat;
				A_CUR_COL3: cur_q[3][23:0] <= rdat;
				A_CUR_EXT: begin
					cur_q[1][27:24] <= rdat[3:0];
					cur_q[2][27:24] <= rdat[7:4];
					cur_q[3][27:24] <= rdat[11:8];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= CTRL_RST;
		end else if (wr && radr == A_CTRL) begin
			ctrl_q <= rdat;
		end
	end

	// Cursor line: two words of 2-bit codes, loaded by successive writes (low then high).
	logic cur_half_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cur_line_q <= 64'h0000000000000000;
			cur_half_q <= 1'b0;
		end else if (wr && radr == A_CUR_LINE) begin
			if (cur_half_q) begin
				cur_line_q[63:32] <= {rdat, 8'h00};
			end else begin
				cur_line_q[31:0] <= {8'h00, rdat};
			end
			cur_half_q <= ~cur_half_q;
		end
	end

	// ============================================================
	// Pixel clock
	logic [2:0] div_sel;
	logic [2:0] pdiv_q;
	logic pix_en_q;
	logic src_tick;
	logic [1:0] src_sel;
	assign src_sel = ctrl_q[C_SRC_LO +: 2];
	assign src_tick = (src_sel < 2'h3) ? pix_src_en[src_sel] : 1'b0;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pdiv_q <= 3'h0;
			pix_en_q <= 1'b0;
		end else begin
			pix_en_q <= 1'b0;
			if (src_tick) begin
				if (pdiv_q >= div_sel) begin
					pdiv_q <= 3'h0;
					pix_en_q <= 1'b1;
				end else begin
					pdiv_q <= pdiv_q + 3'h1;
				end
			end
		end
	end
	assign div_sel = ctrl_q[C_DIV_LO +: 3];

	// ============================================================
	// Input latch and unpacking
	ppop_bpp_e bpp;
	ppop_mode_e mode;
	ppop_bus_e bus;
	logic [DIN_W-1:0] word_q;
	logic [5:0] bit_q;
	logic [5:0] cur_x_q;
	logic [7:0] idx;
	logic [31:0] raw;
	assign bpp = ppop_bpp_e'(ctrl_q[C_BPP_LO +: 3]);
	assign mode = ppop_mode_e'(ctrl_q[C_MODE_LO +: 2]);
	assign bus = ppop_bus_e'(ctrl_q[C_BUS_LO +: 2]);
	// Pixels sit at offsets aligned to their width; a 32-bit bus word wraps at bit 32.
	logic [5:0] step;
	logic [5:0] off;
	logic narrow;
	assign step = 6'h01 << bpp[2:0];
	assign off = bit_q & ~(step - 6'h01);
	assign narrow = (bus == BUS_ASYNC32) || (bus == BUS_VRAM);

	// Sync modes sample on the bus clock enable; async samples on valid when no register write is strobed.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			word_q <= 64'h0000000000000000;
		end else if (din_valid && register_write_strobe_n &&
				(bus == BUS_ASYNC32 || memory_bus_clock)) begin
			case (bus)
				BUS_ASYNC32: word_q <= {32'h00000000, din[31:0]};
				BUS_VRAM: word_q <= {32'h00000000, din[63:32]};
				default: word_q <= din;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bit_q <= 6'h00;
			cur_x_q <= 6'h00;
		end else if (pix_en_q) begin
			bit_q <= (off + step) & (narrow ? 6'h1F : 6'h3F);
			cur_x_q <= cursor_active ? cur_x_q + 6'h01 : 6'h00;
		end
	end

	always_comb begin
		raw = 32'h00000000;
		case (bpp)
			BPP1: raw = {31'h0, word_q[off]};
			BPP2: raw = {30'h0, word_q[off +: 2]};
			BPP4: raw = {28'h0, word_q[off +: 4]};
			BPP8: raw = {24'h0, word_q[off +: 8]};
			BPP16: raw = {16'h0, word_q[off +: 16]};
			BPP32: raw = word_q[off +: 32];
			default: raw = 32'h00000000;
		endcase
	end
	assign idx = raw[7:0];

	// ============================================================
	// Palette, grey and cursor overlay
	logic [LUT_W-1:0] ent;
	logic [1:0] ccode;
	logic [3:0] grey;
	assign ent = lut_q[idx];
	assign ccode = cursor_active ? cur_line_q[cur_x_q[4:0]*2 +: 2] : 2'h0;
	// Panel grey: narrow pixels stretched to 16 levels.
	assign grey = (bpp == BPP1) ? {4{raw[0]}} :
		(bpp == BPP2) ? {raw[1:0], raw[1:0]} : raw[3:0];

	logic [LUT_W-1:0] pix_q;
	logic [3:0] grey_q;
	logic [1:0] qphase_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pix_q <= 28'h0000000;
			grey_q <= 4'h0;
		end else if (pix_en_q) begin
			pix_q <= (ccode == 2'h0) ? ent : cur_q[ccode];
			grey_q <= grey;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			seg_enable <= 8'h00;
		end else begin
			seg_enable <= 8'h01 << (wr ? ptr_q[7:5] : idx[7:5]);
		end
	end

	// ============================================================
	// Output port
	logic [3:0] pnl_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			red_out <= 8'h00;
			green_out <= 8'h00;
			blue_out <= 8'h00;
			external_table_bits <= 4'h0;
			digital_output_port <= 8'h00;
			port_output_clock <= 1'b0;
			qphase_q <= 2'h0;
			pnl_q <= 4'h0;
		end else begin
			red_out <= pix_q[7:0];
			green_out <= pix_q[15:8];
			blue_out <= pix_q[23:16];
			external_table_bits <= pix_q[27:24];
			port_output_clock <= 1'b0;
			if (pix_en_q) begin
				if (mode == MODE_PANEL) begin
					qphase_q <= qphase_q + 2'h1;
					pnl_q <= grey_q;
					if (qphase_q == 2'(PANEL_DIV - 1)) begin
						digital_output_port <= {pnl_q, grey_q};
						port_output_clock <= 1'b1;
					end
				end else begin
					port_output_clock <= 1'b1;
					case (port_source_select)
						SEL_RED: digital_output_port <= pix_q[7:0];
						SEL_GRN: digital_output_port <= pix_q[15:8];
						SEL_BLU: digital_output_port <= pix_q[23:16];
						default: digital_output_port <= {4'h0, pix_q[27:24]};
					endcase
				end
			end
		end
	end

	// ============================================================
	// Checks
	ptr_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wr && radr == A_LUT_DATA |=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("pointer did not step after entry write");
	ptr_wrap_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wr && radr == A_LUT_EXT && ptr_q == 8'hFF |=> ptr_q == 8'h00)
		else $error("pointer did not wrap");
	cur_transp_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pix_en_q && ccode == 2'h0 |=> pix_q == $past(ent))
		else $error("transparent cursor altered pixel");
	cur_colour_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pix_en_q && ccode != 2'h0 |=> pix_q == $past(cur_q[ccode]))
		else $error("cursor colour not applied");
	seg_onehot_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$past(rst_b) |-> $onehot(seg_enable))
		else $error("palette segment enable not one-hot");
	pix_div_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pix_en_q && div_sel != 3'h0 |=> !pix_en_q)
		else $error("pixel enable not divided down");
	port_clk_a: assert property (@(posedge mclk) disable iff (!rst_b)
		port_output_clock |-> $past(pix_en_q))
		else $error("port clock without pixel");
	port_src_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pix_en_q && mode != MODE_PANEL && port_source_select == SEL_GRN
		|=> digital_output_port == $past(pix_q[15:8]))
		else $error("port source select ignored");
	async_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
		bus == BUS_ASYNC32 && din_valid && register_write_strobe_n
		|=> word_q[63:32] == 32'h00000000)
		else $error("upper half used in async mode");
	ctrl_wr_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wr && radr == A_CTRL |=> ctrl_q == $past(rdat))
		else $error("control write lost");
	word_narrow_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pix_en_q && narrow |=> bit_q < 6'h20)
		else $error("unpacker stepped past the 32-bit word");
	panel_quarter_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pix_en_q && mode == MODE_PANEL && qphase_q != 2'(PANEL_DIV - 1) |=> !port_output_clock)
		else $error("port clock faster than a quarter of the pixel rate");
	lut_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wr && radr == A_LUT_DATA |=> lut_q[$past(ptr_q)][23:0] == $past(rdat))
		else $error("palette entry not written");

endmodule // ppop_top

// [tb/ppop_mem_model.sv]
`timescale 1ns/10ps
// ==========
// Memory system and its controller, seen from the device's input bus.
module ppop_mem_model
	import ppop_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// Requests from the bench.
	input wire logic prog_req,
	input wire logic [PROG_W-1:0] prog_word,
	input wire logic pix_req,
	input wire logic [DIN_W-1:0] pix_word,
	input wire logic [1:0] bus_mode,
	input wire logic bus_gate,
	// Device side.
	output logic register_write_strobe_n,
	output logic [DIN_W-1:0] din,
	output logic din_valid,
	output logic memory_bus_clock
);
	// The bus clock stays low in async mode and gates sampling otherwise.
	assign memory_bus_clock = bus_gate && bus_mode != BUS_ASYNC32;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			register_write_strobe_n <= 1'h1;
			din_valid <= 1'h0;
			din <= '0;
		end else begin
			register_write_strobe_n <= !prog_req;
			din_valid <= pix_req && !prog_req;
			if (prog_req) begin
				din <= {32'h0, prog_word};
			end else if (pix_req && bus_mode == BUS_ASYNC32) begin
				din <= {32'h0, pix_word[31:0]};
			end else if (pix_req) begin
				din <= pix_word;
			end else begin
				// An idle bus never repeats its last word.
				din <= ~din;
			end
		end
	end
endmodule // ppop_mem_model

// [tb/ppop_top_tb.sv]
`timescale 1ns/10ps
// ==========
// Self-checking bench for the pixel path.
module ppop_top_tb import ppop_pkg::*;;
	logic mclk, rst_b, prog_req, pix_req, bus_gate, cursor_active;
	logic register_write_strobe_n, din_valid, memory_bus_clock, port_output_clock;
	logic [PROG_W-1:0] prog_word;
	logic [DIN_W-1:0] pix_word, din;
	logic [1:0] bus_mode, port_source_select;
	logic [2:0] pix_src_en;
	logic [7:0] digital_output_port, red_out, green_out, blue_out, seg_enable;
	logic [3:0] external_table_bits;
	int num_errors, checked, cycles, last_k;
	ppop_mem_model ppop_mem_model_i (.mclk(mclk), .rst_b(rst_b), .prog_req(prog_req),
		.prog_word(prog_word), .pix_req(pix_req), .pix_word(pix_word), .bus_mode(bus_mode),
		.bus_gate(bus_gate), .register_write_strobe_n(register_write_strobe_n), .din(din),
		.din_valid(din_valid), .memory_bus_clock(memory_bus_clock));
	ppop_top ppop_top_i (.mclk(mclk), .rst_b(rst_b), .din(din), .din_valid(din_valid),
		.register_write_strobe_n(register_write_strobe_n), .pix_src_en(pix_src_en),
		.memory_bus_clock(memory_bus_clock), .cursor_active(cursor_active),
		.port_source_select(port_source_select), .digital_output_port(digital_output_port),
		.port_output_clock(port_output_clock), .red_out(red_out), .green_out(green_out),
		.blue_out(blue_out), .external_table_bits(external_table_bits), .seg_enable(seg_enable));
	function automatic logic [23:0] col(input int i);
		return 24'h204060 + 24'(i) * 24'h030507;
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		prog_req <= 1'h1;
		prog_word <= {a, d};
		@(posedge mclk);
	endtask
	task automatic ctrl(input logic [2:0] dv, input logic [1:0] sr, input logic [2:0] bp,
		input logic [1:0] md, input logic [1:0] bs);
		wr(A_CTRL, {12'h0, bs, md, bp, sr, dv});
		bus_mode <= bs;
		prog_req <= 1'h0;
	endtask
	// Waits for n port clock pulses; last_k keeps the cycles waited for the last one, its own cycle included.
	task automatic pclk(input int n);
		repeat (n) begin
			last_k = 0;
			do begin
				@(posedge mclk);
				#1;
				last_k++;
			end while (port_output_clock !== 1'h1 && last_k < 200);
			chk("port_clock", port_output_clock, 1'h1);
		end
	endtask
	task automatic see(input logic [23:0] c, input int n);
		pclk(n);
		chk("red", red_out, c[7:0]);
		chk("green", green_out, c[15:8]);
		chk("blue", blue_out, c[23:16]);
	endtask
	task automatic t_palette();
		wr(A_LUT_PTR, 24'hFE);
		for (int i = 0; i < 3; i++) wr(A_LUT_DATA, col(i));
		wr(A_LUT_PTR, 24'hFE);
		wr(A_LUT_EXT, 24'h5);
		wr(A_LUT_EXT, 24'hA);
		wr(8'h00, 24'hFFFFFF);
		ctrl(0, 0, BPP8, MODE_CRT, BUS_ASYNC32);
		for (int i = 0; i < 3; i++) begin
			pix_word <= {8{8'(8'hFE + i)}};
			see(col(i), 12);
		end
		pix_word <= {8{8'hFE}};
		pclk(12);
		chk("ext", external_table_bits, 4'h5);
		for (int s = 0; s < 4; s++) begin
			port_source_select <= 2'(s);
			pclk(4);
			chk("port", s == 3 ? 8'(digital_output_port[3:0]) : digital_output_port,
				s == 3 ? 8'h05 : 8'(col(0) >> 8 * s));
		end
	endtask
	task automatic t_depth();
		for (int i = 0; i < 6; i++) begin
			wr(A_LUT_PTR, 24'((1 << (1 << i)) - 1));
			wr(A_LUT_DATA, col(i + 4));
			ctrl(0, 0, 3'(i), MODE_CRT, BUS_ASYNC32);
			pix_word <= '1;
			see(col(i + 4), 12);
		end
	endtask
	task automatic t_cursor();
		for (int c = 0; c < 2; c++) begin
			wr(A_CUR_COL1, 24'h123456);
			wr(A_CUR_LINE, c ? 24'h0 : 24'h555555);
			wr(A_CUR_LINE, c ? 24'h0 : 24'h555555);
			prog_req <= 1'h0;
			pix_word <= {8{8'hFE}};
			cursor_active <= 1'h1;
			see(c ? col(0) : 24'h123456, 4);
			cursor_active <= 1'h0;
			pclk(40);
		end
	endtask
	task automatic t_rate();
		ctrl(7, 0, BPP8, MODE_CRT, BUS_ASYNC32);
		pclk(4);
		pclk(1);
		chk("gap", last_k, 8);
		ctrl(0, 0, BPP4, MODE_PANEL, BUS_ASYNC32);
		pclk(4);
		pclk(1);
		chk("gap", last_k, 4);
		pix_word <= {16{4'h9}};
		pclk(3);
		chk("panel", digital_output_port, 8'h99);
		ctrl(0, 1, BPP8, MODE_CRT, BUS_ASYNC32);
		pix_src_en <= 3'h2;
		pclk(4);
		pclk(1);
		chk("gap", last_k, 1);
		pix_src_en <= 3'h1;
	endtask
	task automatic t_sync();
		pix_word <= {8{8'hFE}};
		ctrl(0, 0, BPP8, MODE_CRT, BUS_SYNC64);
		see(col(0), 12);
		bus_gate <= 1'h0;
		pix_word <= '1;
		repeat (40) @(posedge mclk);
		#1;
		chk("held", red_out, col(0) & 24'hFF);
		bus_gate <= 1'h1;
		see(col(9), 12);
		ctrl(0, 0, BPP8, MODE_CRT, BUS_VRAM);
		pix_word <= {32'hFEFEFEFE, 32'h0};
		see(col(0), 12);
		ctrl(0, 0, BPP8, MODE_CRT, BUS_SPLIT);
		pix_word <= '1;
		see(col(9), 12);
	endtask
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end
	initial begin
		{rst_b, prog_req, cursor_active, prog_word, port_source_select, bus_mode} = '0;
		{pix_req, bus_gate, pix_src_en, pix_word} = {2'h3, 3'h1, 64'h0};
		repeat (2) @(posedge mclk);
		rst_b <= 1'h1;
		@(posedge mclk);
		#1;
		chk("port", digital_output_port, 8'h00);
		chk("seg", $onehot(seg_enable), 1);
		t_palette();
		t_depth();
		t_cursor();
		t_rate();
		t_sync();
		final_report();
	end
endmodule // ppop_top_tb
